// ==== src/clr_pkg.sv ====
// Constants and state type of the clearing-instruction execute block
// How it works
// - Clear-file zeroes addressed register, sets zero
// - Clear-accumulator zeroes accumulator, sets zero flag
// - Watchdog-clear resets watchdog counter in one cycle
// - Prescaler cleared only when assigned to watchdog
// - Watchdog-clear sets timeout and powerdown flags
package clr_pkg;
	// Opcode patterns, twelve-bit instruction words
	localparam logic [11:0] OP_CLEAR_ACC = 12'h040;
	localparam logic [11:0] OP_WD_CLEAR = 12'h004;
	localparam logic [6:0] OP_CLEAR_FILE_TOP = 7'h03;
	localparam int FILE_ADDR_W = 5;
	localparam int FILE_COUNT = 32;

	// Register port map
	localparam int ADDR_W = 6;
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_STATUS = 6'h01;
	localparam logic [5:0] REG_ACC = 6'h02;
	localparam logic [5:0] REG_WDT = 6'h03;
	localparam logic [5:0] REG_PRE = 6'h04;
	localparam logic [5:0] REG_FILE_BASE = 6'h20;

	// Field positions
	localparam int CTRL_PRE_TO_WD_BIT = 0;
	localparam int STATUS_ZERO_BIT = 0;
	localparam int STATUS_TO_N_BIT = 1;
	localparam int STATUS_PD_N_BIT = 2;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_ZERO = 1'b0;
	localparam logic RST_TO_N = 1'b1;
	localparam logic RST_PD_N = 1'b1;
	localparam logic RST_PRE_TO_WD = 1'b1;
	localparam logic [7:0] CLEARED = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;

	typedef struct packed {
		logic [FILE_COUNT-1:0][7:0] file_regs;
		logic [7:0] acc;
		logic zero;
		logic to_n;
		logic pd_n;
		logic [7:0] wdt;
		logic [7:0] pre;
		logic pre_to_wd;
		logic [2:0] sync;
		logic tick_lvl;
		logic done;
		logic [7:0] rd_data;
	} clr_state_t;
endpackage

// ==== src/clr_dec_if.sv ====
// Decode results passed from the decoder to the execute stage
`timescale 1ns/1ps
interface clr_dec_if;
	logic clear_file_op;
	logic clear_accumulator_op;
	logic watchdog_clear_op;
	logic [4:0] file_addr;

	modport decoder (
		output clear_file_op,
		output clear_accumulator_op,
		output watchdog_clear_op,
		output file_addr
	);
	modport exec (
		input clear_file_op,
		input clear_accumulator_op,
		input watchdog_clear_op,
		input file_addr
	);
endinterface

// ==== src/clr_decode.sv ====
// Opcode decoder for the three clearing instructions
`timescale 1ns/1ps
module clr_decode (
	input wire logic [11:0] instr,
	input wire logic instr_valid,
	clr_dec_if.decoder dec
);
	always_comb
	begin
		dec.clear_file_op = instr_valid
			&& (instr[11:5] == clr_pkg::OP_CLEAR_FILE_TOP);
		dec.clear_accumulator_op = instr_valid
			&& (instr == clr_pkg::OP_CLEAR_ACC);
		dec.watchdog_clear_op = instr_valid
			&& (instr == clr_pkg::OP_WD_CLEAR);
		dec.file_addr = instr[4:0];
	end
endmodule

// ==== src/clr_exec.sv ====
// Execute stage for clear-file, clear-accumulator and watchdog-clear
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module clr_exec (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [11:0] instr,
	input wire logic instr_valid,
	input wire logic wd_tick_pin,
	input wire logic tick_counter_inc,
	input wire logic sleep_enter,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic [7:0] accumulator,
	output logic zero_flag,
	output logic timeout_flag_n,
	output logic powerdown_flag_n,
	output logic [7:0] watchdog_counter,
	output logic [7:0] prescaler,
	output logic instr_done
);
	clr_dec_if dec_bus ();
	clr_pkg::clr_state_t st_r;
	clr_pkg::clr_state_t st_nxt;
	logic agree;
	logic wd_tick;
	logic pre_carry;
	logic wd_step;
	logic tc_step;

	clr_decode u_decode (
		.instr(instr),
		.instr_valid(instr_valid),
		.dec(dec_bus.decoder)
	);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rd_data = clr_pkg::CLEARED;
		st_nxt.done = 1'b0;

		// Watchdog pulse arrives from its own oscillator
		st_nxt.sync = {st_r.sync[1:0], wd_tick_pin};
		agree = (st_r.sync[1] == st_r.sync[2]);
		wd_tick = agree && st_r.sync[2] && !st_r.tick_lvl;
		if (agree)
		begin
			st_nxt.tick_lvl = st_r.sync[2];
		end

		// Shared prescaler serves one owner at a time
		wd_step = 1'b0;
		tc_step = st_r.pre_to_wd ? wd_tick : tick_counter_inc;
		pre_carry = (st_r.pre == clr_pkg::COUNT_MAX);
		if (tc_step)
		begin
			st_nxt.pre = st_r.pre + 8'h01;
			wd_step = st_r.pre_to_wd && pre_carry;
		end
		if (!st_r.pre_to_wd && wd_tick)
		begin
			wd_step = 1'b1;
		end
		if (wd_step)
		begin
			st_nxt.wdt = st_r.wdt + 8'h01;
			if (st_r.wdt == clr_pkg::COUNT_MAX)
			begin
				st_nxt.to_n = 1'b0;
			end
		end
		if (sleep_enter)
		begin
			st_nxt.pd_n = 1'b0;
		end

		// Software writes; instruction effects below take priority
		if (reg_wr)
		begin
			if (reg_addr == clr_pkg::REG_CTRL)
			begin
				st_nxt.pre_to_wd =
					reg_wdata[clr_pkg::CTRL_PRE_TO_WD_BIT];
			end
			else if (reg_addr == clr_pkg::REG_STATUS)
			begin
				st_nxt.zero = reg_wdata[clr_pkg::STATUS_ZERO_BIT];
			end
			else if (reg_addr == clr_pkg::REG_ACC)
			begin
				st_nxt.acc = reg_wdata;
			end
			else if (reg_addr[5] == clr_pkg::REG_FILE_BASE[5])
			begin
				st_nxt.file_regs[reg_addr[4:0]] = reg_wdata;
			end
		end

		if (dec_bus.clear_file_op)
		begin
			st_nxt.file_regs[dec_bus.file_addr] = clr_pkg::CLEARED;
			st_nxt.zero = 1'b1;
			st_nxt.done = 1'b1;
		end
		if (dec_bus.clear_accumulator_op)
		begin
			st_nxt.acc = clr_pkg::CLEARED;
			st_nxt.zero = 1'b1;
			st_nxt.done = 1'b1;
		end
		if (dec_bus.watchdog_clear_op)
		begin
			st_nxt.wdt = clr_pkg::CLEARED;
			// prescaler only when watchdog owns it
			if (st_r.pre_to_wd)
			begin
				st_nxt.pre = clr_pkg::CLEARED;
			end
			st_nxt.to_n = 1'b1;
			st_nxt.pd_n = 1'b1;
			st_nxt.done = 1'b1;
		end
		// zero flag untouched by watchdog-clear
		// (only the branches above touch it)

		// Read data stands for the one cycle after the strobe
		if (reg_rd)
		begin
			if (reg_addr == clr_pkg::REG_CTRL)
			begin
				st_nxt.rd_data[clr_pkg::CTRL_PRE_TO_WD_BIT] =
					st_r.pre_to_wd;
			end
			else if (reg_addr == clr_pkg::REG_STATUS)
			begin
				st_nxt.rd_data[clr_pkg::STATUS_ZERO_BIT] = st_r.zero;
				st_nxt.rd_data[clr_pkg::STATUS_TO_N_BIT] = st_r.to_n;
				st_nxt.rd_data[clr_pkg::STATUS_PD_N_BIT] = st_r.pd_n;
			end
			else if (reg_addr == clr_pkg::REG_ACC)
			begin
				st_nxt.rd_data = st_r.acc;
			end
			else if (reg_addr == clr_pkg::REG_WDT)
			begin
				st_nxt.rd_data = st_r.wdt;
			end
			else if (reg_addr == clr_pkg::REG_PRE)
			begin
				st_nxt.rd_data = st_r.pre;
			end
			else if (reg_addr[5] == clr_pkg::REG_FILE_BASE[5])
			begin
				st_nxt.rd_data = st_r.file_regs[reg_addr[4:0]];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r.file_regs <= '0;
			st_r.acc <= clr_pkg::RST_BYTE;
			st_r.zero <= clr_pkg::RST_ZERO;
			st_r.to_n <= clr_pkg::RST_TO_N;
			st_r.pd_n <= clr_pkg::RST_PD_N;
			st_r.wdt <= clr_pkg::RST_BYTE;
			st_r.pre <= clr_pkg::RST_BYTE;
			st_r.pre_to_wd <= clr_pkg::RST_PRE_TO_WD;
			st_r.sync <= 3'h0;
			st_r.tick_lvl <= 1'b0;
			st_r.done <= 1'b0;
			st_r.rd_data <= clr_pkg::RST_BYTE;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rd_data;
	assign accumulator = st_r.acc;
	assign zero_flag = st_r.zero;
	assign timeout_flag_n = st_r.to_n;
	assign powerdown_flag_n = st_r.pd_n;
	assign watchdog_counter = st_r.wdt;
	assign prescaler = st_r.pre;
	assign instr_done = st_r.done;
endmodule

// ==== test/clr_exec_chk.sv ====
// Assertion checker bound to the clearing-instruction execute block
`timescale 1ns/1ps
module clr_exec_chk (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [11:0] instr,
	input wire logic instr_valid,
	input wire logic sleep_enter,
	input wire logic tick_counter_inc,
	input wire logic [7:0] accumulator,
	input wire logic zero_flag,
	input wire logic timeout_flag_n,
	input wire logic powerdown_flag_n,
	input wire logic [7:0] watchdog_counter,
	input wire logic [7:0] prescaler,
	input wire logic instr_done
);
	logic is_cf, is_ca, is_wd;
	assign is_cf = instr_valid && instr[11:5] == 7'h03;
	assign is_ca = instr_valid && instr == 12'h040;
	assign is_wd = instr_valid && instr == 12'h004;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_clear_file_op_result: assert property (is_cf |=> zero_flag && instr_done)
		else $error("clear-file result wrong");
	a_clracc_result: assert property (is_ca |=> accumulator == 8'h00
		&& zero_flag && instr_done) else $error("clear-acc result wrong");
	a_wd_counter: assert property (is_wd |=> watchdog_counter == 8'h00)
		else $error("watchdog counter not cleared");
	a_wd_prescaler: assert property (is_wd && !tick_counter_inc
		|=> prescaler == 8'h00 || $stable(prescaler))
		else $error("prescaler changed wrongly");
	a_wd_flags: assert property (is_wd |=> timeout_flag_n
		&& powerdown_flag_n) else $error("status flags not set");
	a_clr_keep: assert property ((is_cf || is_ca) && !sleep_enter
		|=> $stable(powerdown_flag_n)) else $error("powerdown flag changed");
endmodule
bind clr_exec clr_exec_chk i_chk (.clk_sys(clk_sys), .reset_n(reset_n),
	.instr(instr), .instr_valid(instr_valid), .sleep_enter(sleep_enter),
	.tick_counter_inc(tick_counter_inc), .accumulator(accumulator),
	.zero_flag(zero_flag), .timeout_flag_n(timeout_flag_n),
	.powerdown_flag_n(powerdown_flag_n),
	.watchdog_counter(watchdog_counter), .prescaler(prescaler),
	.instr_done(instr_done));

// ==== test/clr_exec_tb.sv ====
// Self-checking testbench of the clearing-instruction execute block
`timescale 1ns/1ps
module clr_exec_tb;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] instr = 12'h000;
	logic instr_valid = 1'b0, wd_tick_pin = 1'b0, tick_counter_inc = 1'b0;
	logic sleep_enter = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00, rd;
	wire logic [7:0] reg_rdata, accumulator, watchdog_counter, prescaler;
	wire logic zero_flag, timeout_flag_n, powerdown_flag_n, instr_done;
	int error_cnt = 0, checks_done = 0;
	clr_exec i_clr_exec (.clk_sys(clk_sys), .reset_n(reset_n),
		.instr(instr), .instr_valid(instr_valid), .wd_tick_pin(wd_tick_pin),
		.tick_counter_inc(tick_counter_inc), .sleep_enter(sleep_enter),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .accumulator(accumulator),
		.zero_flag(zero_flag), .timeout_flag_n(timeout_flag_n),
		.powerdown_flag_n(powerdown_flag_n),
		.watchdog_counter(watchdog_counter), .prescaler(prescaler),
		.instr_done(instr_done));
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end
	task chk(input string what, input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rd_reg(input logic [5:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	task exe(input logic [11:0] op);
		@(posedge clk_sys);
		instr <= op;
		instr_valid <= 1'b1;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
	endtask
	// Slow ticks, the pin passes a three-stage synchroniser
	task tick(input int n);
		repeat (n)
		begin
			@(posedge clk_sys) wd_tick_pin <= 1'b1;
			repeat (6) @(posedge clk_sys);
			wd_tick_pin <= 1'b0;
			repeat (6) @(posedge clk_sys);
		end
	endtask
	task t_file;
		wr(6'h3F, 8'h5A);
		wr(6'h3E, 8'hA5);
		wr(6'h01, 8'h00);
		exe(12'h07F);
		chk("done", {7'h00, instr_done}, 8'h01);
		chk("zero", {7'h00, zero_flag}, 8'h01);
		rd_reg(6'h3F);
		chk("file31", rd, 8'h00);
		rd_reg(6'h3E);
		chk("file30", rd, 8'hA5);
	endtask
	task t_acc;
		wr(6'h02, 8'h5A);
		wr(6'h01, 8'h00);
		@(posedge clk_sys) sleep_enter <= 1'b1;
		@(posedge clk_sys) sleep_enter <= 1'b0;
		exe(12'h040);
		chk("acc", accumulator, 8'h00);
		chk("zero", {7'h00, zero_flag}, 8'h01);
		chk("pd", {7'h00, powerdown_flag_n}, 8'h00);
		rd_reg(6'h10);
		chk("unmapped", rd, 8'h00);
		// Neighbouring opcode must not count as a clear
		exe(12'h041);
		chk("no done", {7'h00, instr_done}, 8'h00);
	endtask
	// Mid-run reset brings accumulator, flags, watchdog counter and prescaler back to their idle values
	task t_rst;
		@(posedge clk_sys) reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk("rst acc", accumulator, 8'h00);
		chk("rst zero", {7'h00, zero_flag}, 8'h00);
		chk("rst flags", {6'h00, timeout_flag_n, powerdown_flag_n}, 8'h03);
		chk("rst wdt", watchdog_counter, 8'h00);
		chk("rst pre", prescaler, 8'h00);
	endtask
	task t_wd;
		tick(3);
		chk("pre", prescaler, 8'h03);
		exe(12'h004);
		chk("wdt", watchdog_counter, 8'h00);
		chk("pre", prescaler, 8'h00);
		chk("flags", {6'h00, timeout_flag_n, powerdown_flag_n}, 8'h03);
		chk("zero", {7'h00, zero_flag}, 8'h01);
		// Prescaler now owned by the tick counter
		wr(6'h00, 8'h00);
		tick(2);
		repeat (2)
		begin
			@(posedge clk_sys) tick_counter_inc <= 1'b1;
			@(posedge clk_sys) tick_counter_inc <= 1'b0;
		end
		exe(12'h004);
		chk("wdt", watchdog_counter, 8'h00);
		chk("pre", prescaler, 8'h02);
	endtask
	task stop_test;
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_file;
		t_acc;
		t_wd;
		t_rst;
		stop_test;
	end
	initial
	begin
		#100000;
		error_cnt++;
		stop_test;
	end
endmodule
